/* File: hrn_entry.sv */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module hrn_entry #(
   parameter int NUM_PROT = 8,
   parameter bit RST_DISTINGUISH = 1'b1,
   parameter bit NMI_DISTINGUISH = 1'b1,
   parameter bit HAS_HYP = 1'b1,
   parameter bit HAS_RNMI = 1'b1,
   parameter bit HAS_ATOMIC = 1'b1,
   parameter bit LITTLE_ENDIAN_OK = 1'b1,
   parameter logic [NUM_PROT-1:0] PROT_RST_L = '0,
   parameter logic [2*NUM_PROT-1:0] PROT_RST_A = '0
) (
   input wire logic pclk,                          // Hart and bus clock
   input wire logic presetn,                       // Async reset, active low
   input wire logic psel,                          // APB select
   input wire logic penable,                       // APB access phase
   input wire logic pwrite,                        // APB direction
   input wire logic [7:0] paddr,                   // APB byte address
   input wire logic [31:0] pwdata,                 // APB write data
   output logic [31:0] prdata,                     // APB read data
   output logic pready,                            // APB ready
   output logic pslverr,                           // APB error
   input wire hrn_pkg::hrn_req_s rst_src,          // Soft reset request
   input wire hrn_pkg::hrn_req_s nmi_src,          // Hardware error NMI
   input wire logic [hrn_pkg::XLEN-1:0] cur_pc,    // Interrupted instr address
   input wire hrn_pkg::hrn_upd_s upd,              // Pipeline CSR updates
   input wire logic [NUM_PROT-1:0] prot_we,        // Protection entry write
   input wire logic [2*NUM_PROT-1:0] prot_a_wr,    // Protection mode data
   input wire logic [NUM_PROT-1:0] prot_l_wr,      // Protection lock data
   output logic redirect,                          // Pc redirect pulse
   output logic [hrn_pkg::XLEN-1:0] redirect_pc,   // Redirect target
   output hrn_pkg::hrn_arch_s arch,                // Architectural state
   output logic [hrn_pkg::XLEN-1:0] mepc,          // Exception pc
   output logic [hrn_pkg::XLEN-1:0] mcause,        // Trap cause
   output logic [hrn_pkg::XLEN-1:0] isa,           // Extension register
   output logic [2*NUM_PROT-1:0] prot_a,           // Protection modes
   output logic [NUM_PROT-1:0] prot_l,             // Protection locks
   output logic irq                                // Event interrupt
);

   // ==========================================================
   // Declarations
   // ==========================================================
   // State registers
   hrn_pkg::hrn_arch_s arch_q;
   hrn_pkg::hrn_arch_s arch_d;
   logic [hrn_pkg::XLEN-1:0] epc_q;
   logic [hrn_pkg::XLEN-1:0] cause_q;
   logic [hrn_pkg::XLEN-1:0] isa_q;
   logic [hrn_pkg::XLEN-1:0] pc_q;
   logic redirect_q;
   logic [2*NUM_PROT-1:0] prot_a_q;
   logic [NUM_PROT-1:0] prot_l_q;
   logic [hrn_pkg::EVT_W-1:0] evt_stat_q;
   logic [hrn_pkg::EVT_W-1:0] evt_en_q;
   // Request and bus decode
   logic soft_rst;
   logic nmi_take;
   logic [hrn_pkg::CODE_W-1:0] rst_code;
   logic [hrn_pkg::CODE_W-1:0] nmi_code;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic [hrn_pkg::EVT_W-1:0] evt_set;
   logic [hrn_pkg::EVT_W-1:0] evt_clr;

   // ==========================================================
   // Request decode
   // ==========================================================
   // Sampled synchronous requests, reset wins over NMI
   // synchronous source requests
   assign soft_rst = rst_src.req;
   assign nmi_take = nmi_src.req & ~soft_rst;

   assign rst_code = RST_DISTINGUISH ? rst_src.code : hrn_pkg::CAUSE_FULL_RESET;
   assign nmi_code = NMI_DISTINGUISH ? nmi_src.code : hrn_pkg::CAUSE_NMI_UNKNOWN;

   // ==========================================================
   // Architectural state
   // ==========================================================
   // Legalised next value from pipeline writes
   always_comb begin
      arch_d = arch_q;
      if (upd.arch_we) begin
         arch_d = upd.arch;
         arch_d.spare = 1'b0;
         if (upd.arch.priv == hrn_pkg::PRIV_RSVD) begin
            arch_d.priv = arch_q.priv;
         end
         if (!LITTLE_ENDIAN_OK) begin
            arch_d.machine_big_endian = 1'b1;
         end
         if (!HAS_ATOMIC) begin
            arch_d.resv_valid = 1'b0;
         end
         if (!HAS_RNMI) begin
            arch_d.nmi_enable = 1'b0;
         end
         if (!HAS_HYP || (upd.arch.hgatp_mode != hrn_pkg::MODE_BARE &&
               upd.arch.hgatp_mode != hrn_pkg::MODE_PAGED)) begin
            arch_d.hgatp_mode = HAS_HYP ? arch_q.hgatp_mode : hrn_pkg::MODE_BARE;
         end
         if (!HAS_HYP || (upd.arch.vsatp_mode != hrn_pkg::MODE_BARE &&
               upd.arch.vsatp_mode != hrn_pkg::MODE_PAGED)) begin
            arch_d.vsatp_mode = HAS_HYP ? arch_q.vsatp_mode : hrn_pkg::MODE_BARE;
         end
      end
   end

   // Status, mode and translation fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arch_q.priv <= hrn_pkg::PRIV_M;
         arch_q.spare <= 1'b0;
         arch_q.mie <= 1'b0;
         arch_q.modify_privilege_for_loads_stores <= 1'b0;
         // little-endian start
         // Parts without little-endian support stay big-endian
         arch_q.machine_big_endian <= !LITTLE_ENDIAN_OK;
         arch_q.nmi_enable <= 1'b0;
         arch_q.resv_valid <= 1'b0;
         arch_q.hgatp_mode <= hrn_pkg::MODE_BARE;
         arch_q.vsatp_mode <= hrn_pkg::MODE_BARE;
      end else if (soft_rst) begin
         arch_q.priv <= hrn_pkg::PRIV_M;
         arch_q.spare <= 1'b0;
         arch_q.mie <= 1'b0;
         arch_q.modify_privilege_for_loads_stores <= 1'b0;
         arch_q.machine_big_endian <= !LITTLE_ENDIAN_OK;
         arch_q.nmi_enable <= 1'b0;
         arch_q.resv_valid <= 1'b0;
         arch_q.hgatp_mode <= hrn_pkg::MODE_BARE;
         arch_q.vsatp_mode <= hrn_pkg::MODE_BARE;
      end else if (nmi_take) begin
         arch_q.priv <= hrn_pkg::PRIV_M;
      end else begin
         arch_q <= arch_d;
      end
   end

   // ==========================================================
   // Exception pc and cause
   // ==========================================================
   // Exception pc, cleared by power-on reset, untouched by soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         epc_q <= '0;
      end else if (nmi_take) begin
         epc_q <= cur_pc;
      end else if (!soft_rst && upd.epc_we) begin
         epc_q <= upd.epc;
      end
   end

   // Cause register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= {{(hrn_pkg::XLEN-hrn_pkg::CODE_W){1'b0}}, hrn_pkg::CAUSE_FULL_RESET};
      end else if (soft_rst) begin
         cause_q <= {{(hrn_pkg::XLEN-hrn_pkg::CODE_W){1'b0}}, rst_code};
      end else if (nmi_take) begin
         cause_q <= {1'b1, {(hrn_pkg::XLEN-hrn_pkg::CODE_W-1){1'b0}}, nmi_code};
      end else if (upd.cause_we) begin
         cause_q <= upd.cause;
      end
   end

   // ==========================================================
   // Extension register
   // ==========================================================
   // Reset load and masked pipeline writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isa_q <= hrn_pkg::ISA_MAX;
      end else if (soft_rst) begin
         isa_q <= hrn_pkg::ISA_MAX;
      end else if (!nmi_take && upd.isa_we) begin
         isa_q <= upd.isa & hrn_pkg::ISA_MAX;
      end
   end

   // ==========================================================
   // Program counter redirect
   // ==========================================================
   // One-cycle redirect with its target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= hrn_pkg::RESET_VECTOR;
         redirect_q <= 1'b1;
      end else if (soft_rst) begin
         pc_q <= hrn_pkg::RESET_VECTOR;
         redirect_q <= 1'b1;
      end else if (nmi_take) begin
         pc_q <= hrn_pkg::NMI_VECTOR;
         redirect_q <= 1'b1;
      end else begin
         redirect_q <= 1'b0;
      end
   end

   // ==========================================================
   // Protection entries
   // ==========================================================
   // One register set per entry, locked entries frozen
   for (genvar i = 0; i < NUM_PROT; i++) begin : g_prot
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            prot_a_q[2*i +: 2] <= PROT_RST_A[2*i +: 2];
            prot_l_q[i] <= PROT_RST_L[i];
         end else if (soft_rst) begin
            prot_a_q[2*i +: 2] <= PROT_RST_A[2*i +: 2];
            prot_l_q[i] <= PROT_RST_L[i];
         end else if (!nmi_take && prot_we[i] && !prot_l_q[i]) begin
            prot_a_q[2*i +: 2] <= prot_a_wr[2*i +: 2];
            prot_l_q[i] <= prot_l_wr[i];
         end
      end
   end

   // ==========================================================
   // APB slave
   // ==========================================================
   // Access phase qualifiers, zero wait states
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;

   // Address decode
   always_comb begin
      mapped = 1'b1;
      prdata = '0;
      case (paddr)
         hrn_pkg::OFF_EVT_STAT: prdata[hrn_pkg::EVT_W-1:0] = evt_stat_q;
         hrn_pkg::OFF_EVT_EN: prdata[hrn_pkg::EVT_W-1:0] = evt_en_q;
         hrn_pkg::OFF_EVT_CLR: prdata = '0;
         hrn_pkg::OFF_CAUSE: prdata = cause_q;
         hrn_pkg::OFF_EPC: prdata = epc_q;
         hrn_pkg::OFF_PC: prdata = pc_q;
         hrn_pkg::OFF_ARCH: prdata[$bits(hrn_pkg::hrn_arch_s)-1:0] = arch_q;
         hrn_pkg::OFF_ISA: prdata = isa_q;
         hrn_pkg::OFF_PROT: prdata = {{(32-3*NUM_PROT){1'b0}}, prot_l_q, prot_a_q};
         default: mapped = 1'b0;
      endcase
      // Data only stands during a read access
      if (!rd_acc) begin
         prdata = '0;
      end
   end

   // Unmapped offsets refused
   assign pslverr = psel & penable & ~mapped;

   // ==========================================================
   // Event interrupt
   // ==========================================================
   // Reset and NMI events, write-one-to-clear
   assign evt_set = {nmi_take, soft_rst};
   assign evt_clr = (wr_acc && paddr == hrn_pkg::OFF_EVT_CLR) ?
      pwdata[hrn_pkg::EVT_W-1:0] : '0;

   // Sticky status, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_stat_q <= '0;
      end else begin
         evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
      end
   end

   // Enable mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_en_q <= '0;
      end else if (wr_acc && paddr == hrn_pkg::OFF_EVT_EN) begin
         evt_en_q <= pwdata[hrn_pkg::EVT_W-1:0];
      end
   end

   // Level output while an enabled bit is set
   assign irq = |(evt_stat_q & evt_en_q);

   // ==========================================================
   // Outputs
   // ==========================================================
   // Registered state to the pipeline
   assign redirect = redirect_q;
   assign redirect_pc = pc_q;
   assign arch = arch_q;
   assign mepc = epc_q;
   assign mcause = cause_q;
   assign isa = isa_q;
   assign prot_a = prot_a_q;
   assign prot_l = prot_l_q;

endmodule : hrn_entry

/* File: hrn_entry_bench.sv */
`timescale 1ns/1ps
module hrn_entry_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, redirect, irq, err;
   logic go_rst, go_nmi, go_upd;
   logic [7:0] paddr, code, prot_we, prot_l_wr, prot_l;
   logic [15:0] prot_a_wr, prot_a;
   logic [31:0] pwdata, prdata, redirect_pc, mepc, mcause, isa, cur_pc, pc, rd;
   hrn_pkg::hrn_req_s rst_src, nmi_src;
   hrn_pkg::hrn_upd_s upd, upd_in;
   hrn_pkg::hrn_arch_s arch;
   int error_cnt, checked, cyc;
   logic [7:0] codes [2] = '{8'h05, 8'h00};
   hrn_entry u_hrn_entry (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rst_src(rst_src), .nmi_src(nmi_src), .cur_pc(cur_pc), .upd(upd),
      .prot_we(prot_we), .prot_a_wr(prot_a_wr), .prot_l_wr(prot_l_wr), .redirect(redirect),
      .redirect_pc(redirect_pc), .arch(arch), .mepc(mepc), .mcause(mcause), .isa(isa),
      .prot_a(prot_a), .prot_l(prot_l), .irq(irq));
   hrn_hart_model u_hrn_hart_model (.pclk(pclk), .presetn(presetn), .go_rst(go_rst),
      .go_nmi(go_nmi), .go_upd(go_upd), .code(code), .pc(pc), .upd_in(upd_in),
      .rst_src(rst_src), .nmi_src(nmi_src), .cur_pc(cur_pc), .upd(upd));
   // ==========================================================
   // Clock, timeout and reporting
   // ==========================================================
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ==========================================================
   // APB transfer, one idle cycle after each
   // ==========================================================
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rchk
   // Reset or NMI through the source model
   task evt(input logic r, input logic [7:0] c, input logic [31:0] p);
      code <= c;
      pc <= p;
      go_rst <= r;
      go_nmi <= !r;
      @(posedge pclk);
      go_rst <= 1'b0;
      go_nmi <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : evt
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, go_rst, go_nmi, go_upd} = '0;
      {code, pc, upd_in, prot_we, prot_a_wr, prot_l_wr} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Power-on values
      rchk(hrn_pkg::OFF_ARCH, 32'h0000_0003);
      rchk(hrn_pkg::OFF_ISA, hrn_pkg::ISA_MAX);
      rchk(hrn_pkg::OFF_PC, hrn_pkg::RESET_VECTOR);
      rchk(hrn_pkg::OFF_CAUSE, 32'h0000_0000);
      rchk(hrn_pkg::OFF_PROT, 32'h0000_0000);
      // Pipeline dirties every field but spare, locks all entries
      upd_in.arch_we <= 1'b1;
      upd_in.arch <= 16'h88F8;
      upd_in.isa_we <= 1'b1;
      upd_in.isa <= 32'hFFFF_0000;
      go_upd <= 1'b1;
      {prot_we, prot_a_wr, prot_l_wr} <= '1;
      @(posedge pclk);
      upd_in.arch <= 16'h48FA;
      prot_we <= '0;
      @(posedge pclk);
      go_upd <= 1'b0;
      repeat (2) @(posedge pclk);
      rchk(hrn_pkg::OFF_ARCH, 32'h0000_88F8);
      rchk(hrn_pkg::OFF_ISA, 32'h4000_0000);
      rchk(hrn_pkg::OFF_PROT, 32'h00FF_FFFF);
      // NMI with a named and an unknown source
      for (int i = 0; i < 2; i++) begin
         evt(1'b0, codes[i], 32'h0000_8120 + 32'(i * 4));
         rchk(hrn_pkg::OFF_CAUSE, {1'b1, 23'h00_0000, codes[i]});
         rchk(hrn_pkg::OFF_EPC, 32'h0000_8120 + 32'(i * 4));
         rchk(hrn_pkg::OFF_PC, hrn_pkg::NMI_VECTOR);
         rchk(hrn_pkg::OFF_ARCH, 32'h0000_88FB);
         rchk(hrn_pkg::OFF_ISA, 32'h4000_0000);
         rchk(hrn_pkg::OFF_PROT, 32'h00FF_FFFF);
      end
      // Event interrupt and soft reset
      rchk(hrn_pkg::OFF_EVT_STAT, 32'h0000_0002);
      apb(1'b1, hrn_pkg::OFF_EVT_EN, 32'h0000_0003);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      evt(1'b1, 8'h03, 32'h0000_9000);
      rchk(hrn_pkg::OFF_ARCH, 32'h0000_0003);
      rchk(hrn_pkg::OFF_CAUSE, 32'h0000_0003);
      rchk(hrn_pkg::OFF_ISA, hrn_pkg::ISA_MAX);
      rchk(hrn_pkg::OFF_PC, hrn_pkg::RESET_VECTOR);
      rchk(hrn_pkg::OFF_PROT, 32'h0000_0000);
      rchk(hrn_pkg::OFF_EVT_STAT, 32'h0000_0003);
      apb(1'b1, hrn_pkg::OFF_EVT_CLR, 32'h0000_0001);
      rchk(hrn_pkg::OFF_EVT_STAT, 32'h0000_0002);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      apb(1'b1, hrn_pkg::OFF_EVT_EN, 32'h0000_0000);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      apb(1'b1, hrn_pkg::OFF_EVT_CLR, 32'h0000_0002);
      rchk(hrn_pkg::OFF_EVT_STAT, 32'h0000_0000);
      rchk(hrn_pkg::OFF_EVT_CLR, 32'h0000_0000);
      // Read-only write ignored, unmapped access refused
      apb(1'b1, hrn_pkg::OFF_CAUSE, 32'hFFFF_FFFF);
      rchk(hrn_pkg::OFF_CAUSE, 32'h0000_0003);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      tally_and_finish();
   end
endmodule : hrn_entry_bench

/* File: hrn_entry_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker for reset and NMI entry
// ==========================================================
module hrn_entry_props #(
   parameter int NUM_PROT = 8
) (
   input wire logic pclk, // Hart clock
   input wire logic presetn, // Async reset, active low
   input wire hrn_pkg::hrn_req_s rst_src, // Soft reset request
   input wire hrn_pkg::hrn_req_s nmi_src, // NMI request
   input wire logic [31:0] cur_pc, // Interrupted pc
   input wire logic redirect, // Redirect pulse
   input wire logic [31:0] redirect_pc, // Redirect target
   input wire hrn_pkg::hrn_arch_s arch, // Architectural state
   input wire logic [31:0] mepc, // Exception pc
   input wire logic [31:0] mcause, // Trap cause
   input wire logic [31:0] isa, // Extension register
   input wire logic [2*NUM_PROT-1:0] prot_a, // Protection modes
   input wire logic [NUM_PROT-1:0] prot_l // Protection locks
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic nmi_take;
   logic [13:0] arch_hi;
   // NMI accepted only without a reset request
   assign nmi_take = nmi_src.req && !rst_src.req;
   assign arch_hi = arch[15:2];
   // ==========================================================
   // NMI entry
   // ==========================================================
   AST_NMI_JUMP: assert property (nmi_take |=> redirect &&
      redirect_pc == hrn_pkg::NMI_VECTOR && arch.priv == hrn_pkg::PRIV_M)
      else $error("nmi did not jump to vector in machine mode");
   AST_NMI_EPC: assert property (nmi_take |=> mepc == $past(cur_pc))
      else $error("nmi exception pc not captured");
   AST_NMI_CAUSE: assert property (nmi_take |=>
      mcause == {1'b1, 23'h00_0000, $past(nmi_src.code)})
      else $error("nmi cause wrong");
   AST_NMI_KEEP: assert property (nmi_take |=> arch_hi == $past(arch_hi) &&
      isa == $past(isa) && prot_a == $past(prot_a) && prot_l == $past(prot_l))
      else $error("nmi disturbed other state");
   AST_REDIR_ONE: assert property (redirect && !rst_src.req && !nmi_src.req
      |=> !redirect) else $error("redirect longer than one cycle");
   // ==========================================================
   // Soft reset
   // ==========================================================
   AST_RST_STATE: assert property (rst_src.req |=> arch == 16'h0003 &&
      redirect && redirect_pc == hrn_pkg::RESET_VECTOR)
      else $error("reset state or vector wrong");
   AST_RST_ISA_PROT: assert property (rst_src.req |=>
      isa == hrn_pkg::ISA_MAX && prot_a == '0 && prot_l == '0)
      else $error("reset isa or protection wrong");
   AST_RST_CAUSE: assert property (rst_src.req |=>
      mcause == {24'h00_0000, $past(rst_src.code)}) else $error("reset cause wrong");
   AST_LEGAL: assert property (arch.priv != hrn_pkg::PRIV_RSVD &&
      (arch.hgatp_mode == hrn_pkg::MODE_BARE || arch.hgatp_mode == hrn_pkg::MODE_PAGED) &&
      (arch.vsatp_mode == hrn_pkg::MODE_BARE || arch.vsatp_mode == hrn_pkg::MODE_PAGED))
      else $error("illegal field value held");
endmodule : hrn_entry_props

bind hrn_entry hrn_entry_props #(.NUM_PROT(NUM_PROT)) u_hrn_entry_props (.pclk(pclk),
   .presetn(presetn), .rst_src(rst_src), .nmi_src(nmi_src), .cur_pc(cur_pc),
   .redirect(redirect), .redirect_pc(redirect_pc), .arch(arch), .mepc(mepc),
   .mcause(mcause), .isa(isa), .prot_a(prot_a), .prot_l(prot_l));

/* File: hrn_hart_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Hart pipeline and error source model
// ==========================================================
module hrn_hart_model (
   input wire logic pclk, // Hart clock
   input wire logic presetn, // Async reset, active low
   input wire logic go_rst, // Raise soft reset
   input wire logic go_nmi, // Raise error NMI
   input wire logic go_upd, // Issue pipeline write
   input wire logic [7:0] code, // Cause code
   input wire logic [31:0] pc, // Current pipeline pc
   input wire hrn_pkg::hrn_upd_s upd_in, // Pipeline write content
   output hrn_pkg::hrn_req_s rst_src, // Soft reset request
   output hrn_pkg::hrn_req_s nmi_src, // NMI request
   output logic [31:0] cur_pc, // Interrupted pc
   output hrn_pkg::hrn_upd_s upd // Pipeline write
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_src <= '0;
         nmi_src <= '0;
      end else begin
         rst_src <= '{req: go_rst, code: code};
         nmi_src <= '{req: go_nmi, code: code};
      end
   end
   // Pipeline pc and writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_pc <= '0;
         upd <= '0;
      end else begin
         cur_pc <= pc;
         upd <= go_upd ? upd_in : '0;
      end
   end
endmodule : hrn_hart_model

/* File: hrn_pkg.sv */
// ==========================================================
// Shared constants and carriers for the reset and NMI entry unit
// ==========================================================
package hrn_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int XLEN = 32;
   localparam int CODE_W = 8;
   localparam int MODE_W = 4;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [7:0] OFF_EVT_STAT = 8'h00;
   localparam logic [7:0] OFF_EVT_EN = 8'h04;
   localparam logic [7:0] OFF_EVT_CLR = 8'h08;
   localparam logic [7:0] OFF_CAUSE = 8'h0C;
   localparam logic [7:0] OFF_EPC = 8'h10;
   localparam logic [7:0] OFF_PC = 8'h14;
   localparam logic [7:0] OFF_ARCH = 8'h18;
   localparam logic [7:0] OFF_ISA = 8'h1C;
   localparam logic [7:0] OFF_PROT = 8'h20;

   // ==========================================================
   // Event bit positions
   // ==========================================================
   localparam int EVT_RESET = 0;
   localparam int EVT_NMI = 1;
   localparam int EVT_W = 2;

   // ==========================================================
   // Reset values and codes
   // ==========================================================
   localparam logic [1:0] PRIV_M = 2'h3;
   localparam logic [1:0] PRIV_RSVD = 2'h2;
   localparam logic [CODE_W-1:0] CAUSE_FULL_RESET = 8'h00;
   localparam logic [CODE_W-1:0] CAUSE_NMI_UNKNOWN = 8'h00;
   localparam logic [MODE_W-1:0] MODE_BARE = 4'h0;
   localparam logic [MODE_W-1:0] MODE_PAGED = 4'h8;
   localparam logic [1:0] PROT_A_OFF = 2'h0;
   localparam logic [XLEN-1:0] RESET_VECTOR = 32'h0000_1000;
   localparam logic [XLEN-1:0] NMI_VECTOR = 32'h0000_2000;
   localparam logic [XLEN-1:0] ISA_MAX = 32'h4000_1105;

   // ==========================================================
   // Architectural state carrier
   // ==========================================================
   typedef struct packed {
      logic [MODE_W-1:0] vsatp_mode;   // [15:12]
      logic [MODE_W-1:0] hgatp_mode;   // [11:8]
      logic resv_valid;                // [7]
      logic nmi_enable;                // [6]
      logic machine_big_endian;        // [5]
      logic modify_privilege_for_loads_stores; // [4]
      logic mie;                       // [3]
      logic spare;                     // [2] reads zero
      logic [1:0] priv;                // [1:0]
   } hrn_arch_s;

   // Pipeline update port
   typedef struct packed {
      logic arch_we;
      hrn_arch_s arch;
      logic epc_we;
      logic [XLEN-1:0] epc;
      logic cause_we;
      logic [XLEN-1:0] cause;
      logic isa_we;
      logic [XLEN-1:0] isa;
   } hrn_upd_s;

   // Request from a reset or NMI source
   typedef struct packed {
      logic req;
      logic [CODE_W-1:0] code;
   } hrn_req_s;

endpackage : hrn_pkg
